//--- pkg/tx_lane_level_pkg.sv
/*
  constants and types for the per-lane transmit level control bank.
  assumes a 32-bit plain register port with byte addresses.
*/
package tx_lane_level_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LANE_SEL_W = 4;

  // register byte offsets
  localparam logic [7:0] SERDES_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] TX_LEVEL_CTL_ONE_OFS = 8'h04;
  localparam logic [7:0] SERDES_CONFIG_REG_OFS = 8'h08;
  localparam logic [7:0] PORT_LINK_CONTROL_TWO_OFS = 8'h0c;

  // field positions in the level control register
  localparam int LEVEL_RATE1_LSB = 0;
  localparam int FINE_RATE1_LSB = 5;
  localparam int LEVEL_RATE2_LOW_LSB = 8;
  localparam int FINE_RATE2_LOW_LSB = 13;
  localparam int LEVEL_RATE2_HIGH_LSB = 16;
  localparam int LEVEL_CTL_FIELDS_W = 21;

  // control bit positions in the other registers
  localparam int LANE_SELECT_LSB = 0;
  localparam int LOW_SWING_ENABLE_BIT = 0;
  localparam int DEEMPH_SELECTION_BIT = 0;

  // deemph_selection encoding
  localparam logic DEEMPH_SEL_6P0DB = 1'b0;
  localparam logic DEEMPH_SEL_3P5DB = 1'b1;
  localparam logic LOW_SWING_ON = 1'b1;

  // reset values
  localparam logic [4:0] LEVEL_RATE1_RST = 5'h11;
  localparam logic [2:0] FINE_RATE1_RST = 3'h4;
  localparam logic [4:0] LEVEL_RATE2_LOW_RST = 5'h17;
  localparam logic [2:0] FINE_RATE2_LOW_RST = 3'h4;
  localparam logic [4:0] LEVEL_RATE2_HIGH_RST = 5'h13;
  localparam logic [3:0] LANE_SELECT_RST = 4'hf;

  // packed in register bit order, msb first
  typedef struct packed {
    logic [4:0] full_swing_level_rate2_high_deemph;
    logic [2:0] fine_deemph_rate2_low_deemph;
    logic [4:0] full_swing_level_rate2_low_deemph;
    logic [2:0] fine_deemph_rate1;
    logic [4:0] full_swing_level_rate1;
  } lane_level_fields_s;

  localparam lane_level_fields_s LANE_FIELDS_RST = '{
    full_swing_level_rate2_high_deemph: LEVEL_RATE2_HIGH_RST,
    fine_deemph_rate2_low_deemph: FINE_RATE2_LOW_RST,
    full_swing_level_rate2_low_deemph: LEVEL_RATE2_LOW_RST,
    fine_deemph_rate1: FINE_RATE1_RST,
    full_swing_level_rate1: LEVEL_RATE1_RST
  };

  // what the driver of one lane is told to use
  typedef struct packed {
    logic [4:0] level;
    logic [2:0] fine_deemph;
    logic fine_deemph_valid;
    logic full_swing;
  } lane_drive_s;

endpackage : tx_lane_level_pkg

//--- core/tx_lane_level_ctrl.sv
/*
  per-lane transmit driver level and fine de-emphasis control bank.
  assumes a plain register port (read data one cycle after the read strobe),
  a rate indication from the link, and a separate soft reset that must not
  disturb the sticky level fields.
*/
`timescale 1ns/100ps
module tx_lane_level_ctrl #(
  parameter int NUM_LANES = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_soft_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_rate2,
  output logic [31:0] o_rdata,
  output logic [NUM_LANES*5-1:0] o_level,
  output logic [NUM_LANES*3-1:0] o_fine_deemph,
  output logic [NUM_LANES-1:0] o_fine_deemph_valid,
  output logic o_full_swing
);

  tx_lane_level_pkg::lane_level_fields_s lane_fields_reg [NUM_LANES];
  tx_lane_level_pkg::lane_drive_s drive_next [NUM_LANES];
  logic [3:0] lane_select_reg;
  logic low_swing_enable_reg;
  logic deemph_selection_reg;
  logic [31:0] rdata_next;

  // lowest selected lane supplies read data; none selected reads lane 0
  function automatic int first_lane(input logic [3:0] sel);
    int idx;
    idx = 0;
    for (int k = NUM_LANES - 1; k >= 0; k--)
    begin
      if (k < 4 && sel[k])
      begin
        idx = k;
      end
    end
    return idx;
  endfunction : first_lane

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // lane_select only reaches lanes 0..3; wider builds never pick the rest
  function automatic logic lane_picked(input logic [3:0] sel, input int lane);
    logic picked;
    picked = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      if (k == lane && sel[k])
      begin
        picked = 1'b1;
      end
    end
    return picked;
  endfunction : lane_picked

  // control registers return to their reset values (lane_select to 4'hf) on either reset; they are not sticky
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || i_soft_rst)
    begin
      lane_select_reg <= tx_lane_level_pkg::LANE_SELECT_RST;
      low_swing_enable_reg <= 1'b0;
      deemph_selection_reg <= tx_lane_level_pkg::DEEMPH_SEL_6P0DB;
    end
    else if (i_wr)
    begin
      if (hit(i_addr, tx_lane_level_pkg::SERDES_CONTROL_REG_OFS))
      begin
        lane_select_reg <= i_wdata[tx_lane_level_pkg::LANE_SELECT_LSB +: 4];
      end
      if (hit(i_addr, tx_lane_level_pkg::SERDES_CONFIG_REG_OFS))
      begin
        low_swing_enable_reg <= i_wdata[tx_lane_level_pkg::LOW_SWING_ENABLE_BIT];
      end
      if (hit(i_addr, tx_lane_level_pkg::PORT_LINK_CONTROL_TWO_OFS))
      begin
        deemph_selection_reg <= i_wdata[tx_lane_level_pkg::DEEMPH_SELECTION_BIT];
      end
    end
  end

  // lanes walked inside one process per concern so every array has one writer
  // only the hard reset reaches the level fields
  always_ff @(posedge i_ref_clk)
  begin
    for (int g = 0; g < NUM_LANES; g++)
    begin
      if (i_rst)
      begin
        lane_fields_reg[g] <= tx_lane_level_pkg::LANE_FIELDS_RST;
      end
      else if (i_wr && hit(i_addr, tx_lane_level_pkg::TX_LEVEL_CTL_ONE_OFS)
               && lane_picked(lane_select_reg, g))
      begin
        lane_fields_reg[g] <= tx_lane_level_pkg::lane_level_fields_s'(
          i_wdata[tx_lane_level_pkg::LEVEL_CTL_FIELDS_W-1:0]);
      end
    end
  end

  always_comb
  begin
    for (int g = 0; g < NUM_LANES; g++)
    begin
      drive_next[g].full_swing = low_swing_enable_reg != tx_lane_level_pkg::LOW_SWING_ON;
      if (!i_rate2)
        begin
          drive_next[g].level = lane_fields_reg[g].full_swing_level_rate1;
          drive_next[g].fine_deemph = lane_fields_reg[g].fine_deemph_rate1;
          drive_next[g].fine_deemph_valid = 1'b1;
        end
        else if (deemph_selection_reg == tx_lane_level_pkg::DEEMPH_SEL_3P5DB)
        begin
          drive_next[g].level = lane_fields_reg[g].full_swing_level_rate2_low_deemph;
          drive_next[g].fine_deemph = lane_fields_reg[g].fine_deemph_rate2_low_deemph;
          drive_next[g].fine_deemph_valid = 1'b1;
        end
        else
        begin
          // -6.0dB fine step lives outside this bank
          drive_next[g].level = lane_fields_reg[g].full_swing_level_rate2_high_deemph;
          drive_next[g].fine_deemph = 3'h0;
          drive_next[g].fine_deemph_valid = 1'b0;
        end
        if (!drive_next[g].full_swing)
        begin
          // de-emphasis is off in low swing
          drive_next[g].fine_deemph = 3'h0;
          drive_next[g].fine_deemph_valid = 1'b0;
        end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    for (int g = 0; g < NUM_LANES; g++)
    begin
      if (i_rst)
      begin
        o_level[g*5 +: 5] <= 5'h00;
        o_fine_deemph[g*3 +: 3] <= 3'h0;
        o_fine_deemph_valid[g] <= 1'b0;
      end
      else
      begin
        o_level[g*5 +: 5] <= drive_next[g].level;
        o_fine_deemph[g*3 +: 3] <= drive_next[g].fine_deemph;
        o_fine_deemph_valid[g] <= drive_next[g].fine_deemph_valid;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_full_swing <= 1'b1;
    end
    else
    begin
      o_full_swing <= low_swing_enable_reg != tx_lane_level_pkg::LOW_SWING_ON;
    end
  end

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (i_rd)
    begin
      if (hit(i_addr, tx_lane_level_pkg::SERDES_CONTROL_REG_OFS))
      begin
        rdata_next[tx_lane_level_pkg::LANE_SELECT_LSB +: 4] = lane_select_reg;
      end
      else if (hit(i_addr, tx_lane_level_pkg::TX_LEVEL_CTL_ONE_OFS))
      begin
        rdata_next[tx_lane_level_pkg::LEVEL_CTL_FIELDS_W-1:0] =
          lane_fields_reg[first_lane(lane_select_reg)];
      end
      else if (hit(i_addr, tx_lane_level_pkg::SERDES_CONFIG_REG_OFS))
      begin
        rdata_next[tx_lane_level_pkg::LOW_SWING_ENABLE_BIT] = low_swing_enable_reg;
      end
      else if (hit(i_addr, tx_lane_level_pkg::PORT_LINK_CONTROL_TWO_OFS))
      begin
        rdata_next[tx_lane_level_pkg::DEEMPH_SELECTION_BIT] = deemph_selection_reg;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_rdata <= 32'h0000_0000;
    end
    else
    begin
      o_rdata <= rdata_next;
    end
  end

endmodule : tx_lane_level_ctrl

//--- verif/tx_lane_level_ctrl_asserts.sv
/* checker for the lane level bank, bound to its top module.
   assumes read data lands the cycle after a read strobe. */
`timescale 1ns/100ps
module tx_lane_level_ctrl_chk #(parameter int NUM_LANES = 4) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_soft_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_rate2,
  input wire logic [31:0] o_rdata,
  input wire logic [NUM_LANES*5-1:0] o_level,
  input wire logic [NUM_LANES*3-1:0] o_fine_deemph,
  input wire logic [NUM_LANES-1:0] o_fine_deemph_valid,
  input wire logic o_full_swing
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_rst_vals;
    $past(i_rst, 2) && !$past(i_rst) && !$past(i_rate2)
      |-> o_level[4:0] == 5'h11 && o_fine_deemph[2:0] == 3'h4;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset level values wrong");
  property p_g1_valid;
    !i_rate2 ##1 o_full_swing |-> o_fine_deemph_valid == {NUM_LANES{1'b1}};
  endproperty
  a_g1_valid: assert property (p_g1_valid) else $error("rate1 fine not applied");
  property p_g2_low;
    (i_wr && i_addr == 8'h0c && i_wdata[0] && !i_soft_rst) ##1 i_rate2 ##1 o_full_swing
      |-> o_fine_deemph_valid == {NUM_LANES{1'b1}};
  endproperty
  a_g2_low: assert property (p_g2_low) else $error("rate2 fine not applied");
  property p_soft_high;
    (i_soft_rst && !i_wr) ##1 !i_wr ##1 i_rate2 |=> o_fine_deemph_valid == '0 && o_fine_deemph == '0;
  endproperty
  a_soft_high: assert property (p_soft_high) else $error("fine applied at -6.0dB");
  property p_ls_kill;
    !o_full_swing |-> o_fine_deemph_valid == '0 && o_fine_deemph == '0;
  endproperty
  a_ls_kill: assert property (p_ls_kill) else $error("fine applied in low swing");
  property p_sticky;
    (!i_rate2 && !i_wr) ##1 (i_soft_rst && !i_rate2 && !i_wr) ##1 !i_rate2 |=> $stable(o_level);
  endproperty
  a_sticky: assert property (p_sticky) else $error("level lost on soft reset");
  property p_lse;
    i_wr && i_addr == 8'h08 && i_wdata[0] && !i_soft_rst |=> ##1 !o_full_swing;
  endproperty
  a_lse: assert property (p_lse) else $error("low swing not entered");
  property p_upper_zero;
    i_rd && i_addr == 8'h04 |=> o_rdata[31:21] == 11'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper level bits not zero");
  c_low_swing: cover property (!o_full_swing);
  c_rate2_fine: cover property (i_rate2 ##1 o_fine_deemph_valid[0]);
  c_soft: cover property (i_soft_rst);
endmodule : tx_lane_level_ctrl_chk
bind tx_lane_level_ctrl tx_lane_level_ctrl_chk #(.NUM_LANES(NUM_LANES)) chk_u (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_soft_rst(i_soft_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_rate2(i_rate2), .o_rdata(o_rdata),
  .o_level(o_level), .o_fine_deemph(o_fine_deemph),
  .o_fine_deemph_valid(o_fine_deemph_valid), .o_full_swing(o_full_swing));

//--- verif/testbench.sv
/* self-checking bench for the lane level bank with a per-lane model.
   assumes four lanes and the register offsets of the package. */
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rst = 1, srst = 0, wr = 0, rd = 0, r2 = 0, fs;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, v;
  logic [19:0] lvl;
  logic [11:0] fd;
  logic [3:0] fv, sel = 4'hf;
  logic ls = 0, de = 0;
  logic [20:0] fld [4];
  int n_fail = 0, total_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  tx_lane_level_ctrl #(.NUM_LANES(4)) dut_u (.i_ref_clk(clk), .i_rst(rst), .i_soft_rst(srst),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .i_rate2(r2), .o_rdata(rdat),
    .o_level(lvl), .o_fine_deemph(fd), .o_fine_deemph_valid(fv), .o_full_swing(fs));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
    if (a == 8'h00) sel = d[3:0];
    if (a == 8'h08) ls = d[0];
    if (a == 8'h0c) de = d[0];
    for (int g = 0; g < 4; g++) if (a == 8'h04 && sel[g]) fld[g] = d[20:0];
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 cmp("rdata", e, rdat);
  endtask : rd_reg
  function automatic logic [31:0] lvl_word();
    for (int g = 3; g >= 0; g--) if (sel[g]) lvl_word = {11'h0, fld[g]};
    if (sel == 4'h0) lvl_word = {11'h0, fld[0]};
  endfunction : lvl_word
  task automatic chk_out();
    logic [19:0] el;
    logic [11:0] ef;
    logic [3:0] ev;
    repeat (3) @(posedge clk);
    #1;
    for (int g = 0; g < 4; g++)
    begin
      el[g*5+:5] = !r2 ? fld[g][4:0] : de ? fld[g][12:8] : fld[g][20:16];
      ef[g*3+:3] = ls ? 3'h0 : !r2 ? fld[g][7:5] : de ? fld[g][15:13] : 3'h0;
      ev[g] = !ls && (!r2 || de);
    end
    cmp("level", {12'h0, el}, {12'h0, lvl});
    cmp("fine", {20'h0, ef}, {20'h0, fd});
    cmp("valid", {28'h0, ev}, {28'h0, fv});
    cmp("full_swing", {31'h0, !ls}, {31'h0, fs});
  endtask : chk_out
  initial
  begin
    v = $urandom(32'h295da6e7);
    for (int g = 0; g < 4; g++) fld[g] = {5'h13, 3'h4, 5'h17, 3'h4, 5'h11};
    repeat (16) @(posedge clk);
    rst <= 0;
    chk_out();
    rd_reg(8'h04, lvl_word());
    rd_reg(8'h00, 32'hf);
    wr_reg(8'h04, {11'h0, 5'h13, 3'h4, 5'h17, 3'h4, 5'h11});
    chk_out();
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(8'h00, $urandom);
      wr_reg(8'h04, $urandom);
      for (int m = 0; m < 8; m++)
      begin
        r2 <= m[0];
        wr_reg(8'h0c, m[1]);
        wr_reg(8'h08, m[2]);
        chk_out();
      end
      rd_reg(8'h04, lvl_word());
      rd_reg(8'h08, {31'h0, ls});
    end
    r2 <= 0;
    @(posedge clk);
    srst <= 1;
    @(posedge clk);
    srst <= 0;
    sel = 4'hf;
    ls = 0;
    de = 0;
    @(posedge clk);
    r2 <= 1;
    chk_out();
    rd_reg(8'h04, lvl_word());
    rd_reg(8'h10, 32'h0);
    complete_run();
  end
endmodule : testbench
